/* hw/dspd_consts.svh */
// Constants of the signal-processor decode core: offsets, opcodes, sizes
`ifndef DSPD_CONSTS_SVH
`define DSPD_CONSTS_SVH
// ----------------------------------------
// Register offsets on the AHB-Lite slave
// ----------------------------------------
`define DSPD_REG_CTRL 8'h00
`define DSPD_REG_STATUS 8'h04
`define DSPD_REG_ACC 8'h08
`define DSPD_REG_AUX 8'h0C
`define DSPD_REG_PROD 8'h10
`define DSPD_REG_ROM_ADDR 8'h14
`define DSPD_REG_ROM_DATA 8'h18
`define DSPD_RUN_RST 1'b0
// ----------------------------------------
// Memory sizes, vectors
// ----------------------------------------
`define DSPD_ROM_WORDS 1536
`define DSPD_RAM_WORDS 144
`define DSPD_STACK_DEPTH 4
`define DSPD_RESET_VEC 12'h000
`define DSPD_INT_VEC 12'h002
// ----------------------------------------
// Instruction fields
// ----------------------------------------
`define DSPD_IND_BIT 7
`define DSPD_INC_BIT 5
`define DSPD_DEC_BIT 4
`define DSPD_KEEP_ARP_BIT 3
// ----------------------------------------
// Opcodes (high byte unless noted)
// ----------------------------------------
`define DSPD_PFX_ADDSUB 3'h0
`define DSPD_PFX_LAC 4'h2
`define DSPD_PFX_MULTIPLY_IMMEDIATE_OP 3'h4
`define DSPD_PFX_STORE_ACC_HIGH_OP 5'h0B
`define DSPD_PFX_IN 5'h08
`define DSPD_PFX_OUT 5'h09
`define DSPD_PFX_LAR 7'h1C
`define DSPD_PFX_SAR 7'h18
`define DSPD_PFX_LOAD_AUX_IMMEDIATE_OP 7'h38
`define DSPD_OP_STORE_ACC_LOW_OP 8'h50
`define DSPD_OP_ADD_HIGH_OP 8'h60
`define DSPD_OP_ADD_UNSIGNED_OP 8'h61
`define DSPD_OP_SUBTRACT_HIGH_OP 8'h62
`define DSPD_OP_SUBTRACT_UNSIGNED_OP 8'h63
`define DSPD_OP_CLEAR_LOAD_HIGH_OP 8'h65
`define DSPD_OP_CLEAR_LOAD_LOW_OP 8'h66
`define DSPD_OP_LT 8'h6A
`define DSPD_OP_LOAD_PAGE_IMMEDIATE_OP 8'h6E
`define DSPD_OP_LDP 8'h6F
`define DSPD_OP_LOAD_ACC_IMMEDIATE_OP 8'h7E
`define DSPD_OP_GRP 8'h7F
`define DSPD_BR_NIB 4'hF
`define DSPD_OP_BRANCH_AUX_NONZERO_OP 8'hF4
`define DSPD_OP_BV 8'hF5
`define DSPD_OP_BRANCH_ON_POLL_LOW_OP 8'hF6
`define DSPD_OP_CALL 8'hF8
`define DSPD_OP_B 8'hF9
`define DSPD_OP_BLZ 8'hFA
`define DSPD_OP_BLEZ 8'hFB
`define DSPD_OP_BGZ 8'hFC
`define DSPD_OP_BGEZ 8'hFD
`define DSPD_OP_BNZ 8'hFE
`define DSPD_OP_BZ 8'hFF
`define DSPD_W_DINT 16'h7F81
`define DSPD_W_EINT 16'h7F82
`define DSPD_W_CALL_FROM_ACC_OP 16'h7F8C
`define DSPD_W_RET 16'h7F8D
`endif

/* hw/dspd_core.sv */
// Decode, addressing and program-flow core of a 16-bit fixed-point DSP
`timescale 1ns/1ps
`default_nettype none
`include "dspd_consts.svh"

module dspd_core
    import dspd_pkg::*;
#(
    parameter int ROM_WORDS = `DSPD_ROM_WORDS,
    parameter int RAM_WORDS = `DSPD_RAM_WORDS,
    parameter int STACK_DEPTH = `DSPD_STACK_DEPTH
) (
    input wire logic hclk, // System clock
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size, words only
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response
    output logic [31:0] hrdata, // AHB read data
    input wire logic memory_map_select, // High maps internal ROM
    input wire logic poll_test_input_n, // Polling pin, active low
    input wire logic int_req_n, // Interrupt pin, active low
    input wire logic [15:0] ext_din, // Data bus input
    output dspd_bus_s ext_bus // Address, data and strobes
);
    localparam int RAW = $clog2(ROM_WORDS);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (ROM_WORDS < 2 || ROM_WORDS > 4096 || RAM_WORDS > 256 || STACK_DEPTH < 2) begin : g_chk
        $error("dspd_core: unsupported size parameter");
    end

    dspd_state_e state;
    logic [11:0] pc;
    logic [15:0] ir;
    logic [15:0] word2;
    logic [15:0] ar [2];
    logic aux_reg_pointer;
    logic dp;
    logic [31:0] acc;
    logic ovf;
    logic [15:0] t_reg;
    logic [31:0] p_reg;
    logic inte;
    logic int_pend;
    logic run;
    logic [RAW-1:0] rom_addr;
    logic [15:0] rom [ROM_WORDS];
    logic [15:0] ram [RAM_WORDS];
    logic [11:0] stack [STACK_DEPTH];
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic int_prev;
    logic [7:0] io_dma;
    logic [15:0] out_data;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Bit 0 interrupt, bit 1 poll, bit 2 mode select
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1 <= 3'h3;
            sync2 <= 3'h3;
            int_prev <= 1'b1;
        end else begin
            sync1 <= {memory_map_select, poll_test_input_n, int_req_n};
            sync2 <= sync1;
            int_prev <= sync2[0];
        end
    end

    logic mc_mode;
    logic poll_low;
    logic int_fall;
    assign mc_mode = sync2[2];
    assign poll_low = !sync2[1];
    assign int_fall = int_prev && !sync2[0];

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic [7:0] hi;
    logic is_imm;
    logic is_br;
    logic is_in;
    logic is_out;
    logic slow;
    logic mem_op;
    logic [7:0] dma;
    logic [15:0] opnd;
    logic int_fetch;
    logic [15:0] fetch_word;
    logic take_int;
    assign hi = ir[15:8];
    // Immediate forms never touch data RAM nor step the aux registers
    assign is_imm = (ir[15:13] == `DSPD_PFX_MULTIPLY_IMMEDIATE_OP) || (hi == `DSPD_OP_LOAD_ACC_IMMEDIATE_OP)
        || (ir[15:9] == `DSPD_PFX_LOAD_AUX_IMMEDIATE_OP) || (hi == `DSPD_OP_LOAD_PAGE_IMMEDIATE_OP);
    assign is_br = (ir[15:12] == `DSPD_BR_NIB);
    assign is_in = (ir[15:11] == `DSPD_PFX_IN);
    assign is_out = (ir[15:11] == `DSPD_PFX_OUT);
    assign slow = is_in || is_out || ir == `DSPD_W_CALL_FROM_ACC_OP || ir == `DSPD_W_RET;
    assign mem_op = !is_imm && !is_br && hi != `DSPD_OP_GRP;
    // Operand address: aux register low byte or page bit with offset
    assign dma = ir[`DSPD_IND_BIT] ? ar[aux_reg_pointer][7:0] : {dp, ir[6:0]};
    // Addresses past the RAM read as zero
    assign opnd = (dma < RAM_WORDS) ? ram[dma] : 16'h0000;
    // Internal ROM only in the mapped mode and below its size
    assign int_fetch = mc_mode && (pc < ROM_WORDS);
    assign fetch_word = int_fetch ? rom[pc[RAW-1:0]] : ext_din;
    assign take_int = (state == ST_FETCH) && run && int_pend && inte;

    // Branch condition
    logic br_take;
    always_comb begin
        case (hi)
            `DSPD_OP_BRANCH_AUX_NONZERO_OP: br_take = (ar[aux_reg_pointer] != 16'h0000);
            `DSPD_OP_BV: br_take = ovf;
            `DSPD_OP_BRANCH_ON_POLL_LOW_OP: br_take = poll_low;
            `DSPD_OP_CALL: br_take = 1'b1;
            `DSPD_OP_B: br_take = 1'b1;
            `DSPD_OP_BLZ: br_take = acc[31];
            `DSPD_OP_BLEZ: br_take = acc[31] || (acc == 32'h0000_0000);
            `DSPD_OP_BGZ: br_take = !acc[31] && (acc != 32'h0000_0000);
            `DSPD_OP_BGEZ: br_take = !acc[31];
            `DSPD_OP_BNZ: br_take = (acc != 32'h0000_0000);
            `DSPD_OP_BZ: br_take = (acc == 32'h0000_0000);
            default: br_take = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Accumulator datapath
    // ----------------------------------------
    logic [31:0] sx;
    logic [31:0] zx;
    logic [31:0] alu_b;
    logic [31:0] alu_r;
    logic [31:0] next_acc;
    logic alu_en;
    logic alu_sub;
    logic next_ovf;
    always_comb begin
        sx = {{16{opnd[15]}}, opnd};
        zx = {16'h0000, opnd};
        alu_b = 32'h0000_0000;
        alu_en = 1'b0;
        alu_sub = 1'b0;
        if (ir[15:13] == `DSPD_PFX_ADDSUB) begin
            alu_b = sx << ir[11:8];
            alu_en = 1'b1;
            alu_sub = ir[12];
        end else if (hi == `DSPD_OP_ADD_HIGH_OP || hi == `DSPD_OP_SUBTRACT_HIGH_OP) begin
            alu_b = {opnd, 16'h0000};
            alu_en = 1'b1;
            alu_sub = (hi == `DSPD_OP_SUBTRACT_HIGH_OP);
        end else if (hi == `DSPD_OP_ADD_UNSIGNED_OP || hi == `DSPD_OP_SUBTRACT_UNSIGNED_OP) begin
            alu_b = zx;
            alu_en = 1'b1;
            alu_sub = (hi == `DSPD_OP_SUBTRACT_UNSIGNED_OP);
        end
        alu_r = alu_sub ? acc - alu_b : acc + alu_b;
        next_ovf = alu_en && (alu_r[31] != acc[31])
            && (alu_sub ? (acc[31] != alu_b[31]) : (acc[31] == alu_b[31]));
        next_acc = alu_en ? alu_r : acc;
        if (ir[15:12] == `DSPD_PFX_LAC) begin
            next_acc = sx << ir[11:8];
        end
        if (hi == `DSPD_OP_CLEAR_LOAD_HIGH_OP) begin
            next_acc = {opnd, 16'h0000};
        end
        if (hi == `DSPD_OP_CLEAR_LOAD_LOW_OP) begin
            next_acc = zx;
        end
        if (hi == `DSPD_OP_LOAD_ACC_IMMEDIATE_OP) begin
            next_acc = {24'h00_0000, ir[7:0]};
        end
    end

    // Accumulator, overflow and multiplier registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc <= 32'h0000_0000;
            ovf <= 1'b0;
            t_reg <= 16'h0000;
            p_reg <= 32'h0000_0000;
        end else if (state == ST_EXEC) begin
            acc <= next_acc;
            if (next_ovf) begin
                ovf <= 1'b1;
            end
            if (hi == `DSPD_OP_LT) begin
                t_reg <= opnd;
            end
            if (ir[15:13] == `DSPD_PFX_MULTIPLY_IMMEDIATE_OP) begin
                p_reg <= {{16{t_reg[15]}}, t_reg} * {{19{ir[12]}}, ir[12:0]};
            end
        end else if (state == ST_EXEC2 && hi == `DSPD_OP_BV) begin
            ovf <= 1'b0; // Overflow branch consumes the flag, taken or not
        end
    end

    // ----------------------------------------
    // Aux registers, pointer and page
    // ----------------------------------------
    // Load forms are written last so they win over the indirect step
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ar[0] <= 16'h0000;
            ar[1] <= 16'h0000;
            aux_reg_pointer <= 1'b0;
            dp <= 1'b0;
        end else if (state == ST_EXEC) begin
            if (mem_op && ir[`DSPD_IND_BIT]) begin
                if (ir[`DSPD_INC_BIT]) begin
                    ar[aux_reg_pointer] <= ar[aux_reg_pointer] + 16'h0001;
                end else if (ir[`DSPD_DEC_BIT]) begin
                    ar[aux_reg_pointer] <= ar[aux_reg_pointer] - 16'h0001;
                end
                if (!ir[`DSPD_KEEP_ARP_BIT]) begin
                    aux_reg_pointer <= ir[0];
                end
            end
            if (ir[15:9] == `DSPD_PFX_LAR) begin
                ar[ir[8]] <= opnd;
            end
            if (ir[15:9] == `DSPD_PFX_LOAD_AUX_IMMEDIATE_OP) begin
                ar[ir[8]] <= {8'h00, ir[7:0]};
            end
            if (hi == `DSPD_OP_LDP) begin
                dp <= opnd[0];
            end
            if (hi == `DSPD_OP_LOAD_PAGE_IMMEDIATE_OP) begin
                dp <= ir[0];
            end
        end
    end

    // ----------------------------------------
    // Data RAM and port staging
    // ----------------------------------------
    logic [31:0] acc_sh;
    assign acc_sh = acc << ir[10:8];
    // RAM has no reset; contents are undefined after power-up
    always_ff @(posedge hclk) begin
        if (state == ST_EXEC && dma < RAM_WORDS) begin
            if (ir[15:11] == `DSPD_PFX_STORE_ACC_HIGH_OP) begin
                ram[dma] <= acc_sh[31:16];
            end else if (hi == `DSPD_OP_STORE_ACC_LOW_OP) begin
                ram[dma] <= acc[15:0];
            end else if (ir[15:9] == `DSPD_PFX_SAR) begin
                ram[dma] <= ar[ir[8]];
            end
        end else if (state == ST_EXEC2 && is_in && io_dma < RAM_WORDS) begin
            ram[io_dma] <= ext_din;
        end
    end

    // Address and data captured before the aux step moves them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_dma <= 8'h00;
            out_data <= 16'h0000;
        end else if (state == ST_EXEC && (is_in || is_out)) begin
            io_dma <= dma;
            out_data <= opnd;
        end
    end

    // ----------------------------------------
    // Program flow
    // ----------------------------------------
    logic push;
    logic pop;
    assign push = take_int || (state == ST_EXEC2
        && ((hi == `DSPD_OP_CALL) || ir == `DSPD_W_CALL_FROM_ACC_OP));
    assign pop = (state == ST_EXEC2) && (ir == `DSPD_W_RET);

    // Return stack; the deepest entry is kept on pop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack[i] <= 12'h000;
            end
        end else if (push) begin
            for (int i = STACK_DEPTH - 1; i > 0; i--) begin
                stack[i] <= stack[i-1];
            end
            stack[0] <= pc;
        end else if (pop) begin
            for (int i = 0; i < STACK_DEPTH - 1; i++) begin
                stack[i] <= stack[i+1];
            end
        end
    end

    // Sequencer: one instruction cycle is a fetch edge plus an execute edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_FETCH;
            pc <= `DSPD_RESET_VEC;
            ir <= 16'h0000;
            word2 <= 16'h0000;
            inte <= 1'b0;
        end else begin
            unique case (state)
                ST_FETCH: begin
                    if (take_int) begin
                        pc <= `DSPD_INT_VEC;
                        inte <= 1'b0;
                    end else if (run) begin
                        ir <= fetch_word;
                        pc <= pc + 12'h001;
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (ir == `DSPD_W_EINT) begin
                        inte <= 1'b1;
                    end
                    if (ir == `DSPD_W_DINT) begin
                        inte <= 1'b0;
                    end
                    if (is_br) begin
                        state <= ST_FETCH2;
                    end else if (slow) begin
                        state <= ST_EXEC2;
                    end else begin
                        state <= ST_FETCH;
                    end
                end
                ST_FETCH2: begin
                    word2 <= fetch_word;
                    pc <= pc + 12'h001;
                    state <= ST_EXEC2;
                end
                ST_EXEC2: begin
                    if (is_br && br_take) begin
                        pc <= word2[11:0];
                    end else if (ir == `DSPD_W_CALL_FROM_ACC_OP) begin
                        pc <= acc[11:0];
                    end else if (pop) begin
                        pc <= stack[0];
                    end
                    state <= ST_FETCH;
                end
            endcase
        end
    end

    // Interrupt latch: a new falling edge beats the clear on acceptance
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_pend <= 1'b0;
        end else if (int_fall) begin
            int_pend <= 1'b1;
        end else if (take_int) begin
            int_pend <= 1'b0;
        end
    end

    // ----------------------------------------
    // External bus pins
    // ----------------------------------------
    logic port_cyc;
    assign port_cyc = (state == ST_EXEC2) && (is_in || is_out);
    assign ext_bus.addr = port_cyc ? {9'h000, ir[10:8]} : pc;
    assign ext_bus.dout = out_data;
    assign ext_bus.we_n = !(port_cyc && is_out);
    assign ext_bus.d_oe_n = !(port_cyc && is_out);
    assign ext_bus.den_n = !(port_cyc && is_in);
    assign ext_bus.men_n = !(((state == ST_FETCH && run && !take_int) || state == ST_FETCH2)
        && !int_fetch);

    // ----------------------------------------
    // AHB-Lite register slave
    // ----------------------------------------
    logic dph_act;
    logic dph_wr;
    logic [7:0] dph_addr;
    logic [31:0] rd_mux;
    assign hreadyout = 1'b1; // Zero wait states
    assign hresp = 1'b0;

    always_comb begin
        case (haddr[7:0])
            `DSPD_REG_CTRL: rd_mux = {31'h0000_0000, run};
            `DSPD_REG_STATUS: rd_mux = {12'h000, ovf, inte, aux_reg_pointer, dp, 4'h0, pc};
            `DSPD_REG_ACC: rd_mux = acc;
            `DSPD_REG_AUX: rd_mux = {ar[1], ar[0]};
            `DSPD_REG_PROD: rd_mux = p_reg;
            `DSPD_REG_ROM_ADDR: rd_mux = 32'(rom_addr);
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Address phase capture; read data registered for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_act <= 1'b0;
            dph_wr <= 1'b0;
            dph_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else if (hready) begin
            dph_act <= hsel && htrans[1];
            dph_wr <= hwrite;
            dph_addr <= haddr[7:0];
            if (hsel && htrans[1] && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // Control writes; the data port auto-increments for bulk loading
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run <= `DSPD_RUN_RST;
            rom_addr <= '0;
        end else if (dph_act && dph_wr) begin
            if (dph_addr == `DSPD_REG_CTRL) begin
                run <= hwdata[0];
            end
            if (dph_addr == `DSPD_REG_ROM_ADDR) begin
                rom_addr <= hwdata[RAW-1:0];
            end
            if (dph_addr == `DSPD_REG_ROM_DATA) begin
                rom_addr <= rom_addr + 1'b1;
            end
        end
    end

    // Program ROM image, loaded by software while the core is stopped
    always_ff @(posedge hclk) begin
        if (dph_act && dph_wr && dph_addr == `DSPD_REG_ROM_DATA && rom_addr < ROM_WORDS) begin
            rom[rom_addr] <= hwdata[15:0];
        end
    end

endmodule : dspd_core
`default_nettype wire

/* hw/dspd_pkg.sv */
// Types shared by the signal-processor decode core
package dspd_pkg;
    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_FETCH = 4'b0001,
        ST_EXEC = 4'b0010,
        ST_FETCH2 = 4'b0100,
        ST_EXEC2 = 4'b1000
    } dspd_state_e;
    // External bus pins driven by the core
    typedef struct packed {
        logic [11:0] addr;
        logic [15:0] dout;
        logic d_oe_n;
        logic men_n;
        logic den_n;
        logic we_n;
    } dspd_bus_s;
endpackage : dspd_pkg

/* tb/dspd_core_props.sv */
// Pin-level checker of the decode core, bound to every core instance
`timescale 1ns/1ps
`default_nettype none
module dspd_core_props
    import dspd_pkg::*;
(
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset, active low
    input wire logic hreadyout, // Slave ready
    input wire logic hresp, // Slave response
    input wire logic memory_map_select, // Mode pin
    input wire dspd_bus_s ext_bus // Core pins
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic port_w = !ext_bus.we_n || !ext_bus.den_n; // Any port cycle
    property p_fetch_pulse; !ext_bus.men_n |=> ext_bus.men_n; endproperty
    property p_port_addr; port_w |-> ext_bus.addr[11:3] == 9'h000; endproperty
    property p_port_pulse; port_w |=> ext_bus.we_n && ext_bus.den_n; endproperty
    property p_port_drive; ext_bus.d_oe_n == ext_bus.we_n; endproperty
    property p_port_nofetch; port_w |-> ext_bus.men_n && (ext_bus.we_n || ext_bus.den_n);
    endproperty
    // Port cycle is the third clock of its instruction, after fetch and execute, never the first
    property p_port_gap; port_w |-> $past(ext_bus.we_n) && $past(ext_bus.den_n); endproperty
    // Pin held long enough to pass the synchroniser before it counts
    property p_rom_internal;
        memory_map_select && $past(memory_map_select) && $past(memory_map_select, 2) &&
        $past(memory_map_select, 3) && ext_bus.addr < 12'h600 |-> ext_bus.men_n;
    endproperty
    property p_bus_okay; hreadyout && !hresp; endproperty
    a_fetch_pulse: assert property (p_fetch_pulse) else $error("fetch strobe held");
    a_port_addr: assert property (p_port_addr) else $error("port address high");
    a_port_pulse: assert property (p_port_pulse) else $error("port strobe held");
    a_port_drive: assert property (p_port_drive) else $error("bus drive mismatch");
    a_port_nofetch: assert property (p_port_nofetch) else $error("strobe clash");
    a_port_gap: assert property (p_port_gap) else $error("port in first cycle");
    a_rom_internal: assert property (p_rom_internal) else $error("rom fetched out");
    a_bus_okay: assert property (p_bus_okay) else $error("bus wait or error");
    c_out: cover property (!ext_bus.we_n);
    c_in: cover property (!ext_bus.den_n);
    c_fetch: cover property (!ext_bus.men_n);
endmodule : dspd_core_props
bind dspd_core dspd_core_props chk_u (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
    .hresp(hresp), .memory_map_select(memory_map_select), .ext_bus(ext_bus));
`default_nettype wire

/* tb/dspd_core_tb.sv */
// Self-checking bench of the decode core with its external memory
`timescale 1ns/1ps
`default_nettype none
`include "dspd_consts.svh"
module dspd_core_tb
    import dspd_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic mms = 1'b0;
    logic poll_n = 1'b1;
    logic irq_n = 1'b1;
    logic [15:0] ext_din;
    dspd_bus_s ext_bus;
    int mismatches = 0;
    int tests_run = 0;
    always #5 hclk = ~hclk;
    dspd_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .memory_map_select(mms),
        .poll_test_input_n(poll_n), .int_req_n(irq_n), .ext_din(ext_din), .ext_bus(ext_bus));
    dspd_ext_mem mem_u (.hclk(hclk), .ext_bus(ext_bus), .ext_din(ext_din));
    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic final_report(input logic hung);
        if (hung) mismatches++;
        if (mismatches == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Bounded wait for ready; a hang ends the run
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) final_report(1'b1);
            @(posedge hclk);
        end
    endtask : wait_rdy
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : ahb
    // Start the core and poll the program counter until it reaches its idle loop
    task automatic run_to(input logic [10:0] pw);
        logic [31:0] r;
        int n;
        n = 0;
        ahb(1'b1, `DSPD_REG_CTRL, 32'h1, r);
        do begin
            ahb(1'b0, `DSPD_REG_STATUS, 32'h0, r);
            n++;
        end while (r[11:1] !== pw && n < 60);
        if (n >= 60) final_report(1'b1);
    endtask : run_to
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic proc_mode_prog();
        logic [31:0] r;
        logic [15:0] p [12];
        p = '{16'h7E05, 16'h5010, 16'h4B10, 16'h7020, 16'h50A8, 16'h4511, 16'h6611,
            16'hF800, 16'h0200, 16'h6E00, 16'hF900, 16'h000A};
        for (int i = 0; i < 12; i++) mem_u.prog[i] = p[i];
        mem_u.prog[12'h200] = 16'h7F8D;
        mem_u.port_in[5] = 16'hC3A5;
        run_to(11'h005);
        ahb(1'b0, `DSPD_REG_ACC, 32'h0, r);
        chk(r, 32'h0000C3A5);
        ahb(1'b0, `DSPD_REG_AUX, 32'h0, r);
        chk(r, 32'h00000021);
        chk({29'h0, mem_u.out_port}, 32'h3);
        chk({16'h0, mem_u.out_word}, 32'h5);
    endtask : proc_mode_prog
    // Internal ROM program branches to an external loop above the ROM
    task automatic comp_mode_prog();
        logic [31:0] r;
        logic [15:0] p [3];
        p = '{16'h7E7A, 16'hF900, 16'h0700};
        mms <= 1'b1;
        hresetn <= 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b1, `DSPD_REG_ROM_ADDR, 32'h0, r);
        for (int i = 0; i < 3; i++) ahb(1'b1, `DSPD_REG_ROM_DATA, {16'h0, p[i]}, r);
        mem_u.prog[12'h700] = 16'hF900;
        mem_u.prog[12'h701] = 16'h0700;
        run_to(11'h380);
        ahb(1'b0, `DSPD_REG_ACC, 32'h0, r);
        chk(r, 32'h0000007A);
        ahb(1'b0, 8'h1C, 32'h0, r);
        chk(r, 32'h0);
    endtask : comp_mode_prog
    // Poll loop branches out once the pin drops; an enabled interrupt runs its handler
    task automatic irq_poll_prog();
        logic [31:0] r;
        logic [15:0] p [16];
        int n;
        p = '{16'hF900, 16'h0008, 16'h7E33, 16'h7F8D, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
            16'hF600, 16'h000C, 16'hF900, 16'h0008, 16'h7F82, 16'hF900, 16'h000D, 16'h0000};
        n = 0;
        mms <= 1'b0;
        hresetn <= 1'b0;
        for (int i = 0; i < 16; i++) mem_u.prog[i] = p[i];
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        run_to(11'h005);
        poll_n <= 1'b0;
        run_to(11'h007);
        irq_n <= 1'b0;
        do begin
            ahb(1'b0, `DSPD_REG_ACC, 32'h0, r);
            n++;
        end while (r !== 32'h00000033 && n < 30);
        if (n >= 30) final_report(1'b1);
        chk(r, 32'h00000033);
        ahb(1'b0, `DSPD_REG_STATUS, 32'h0, r);
        chk({31'h0, r[18]}, 32'h0);
        run_to(11'h007);
        irq_n <= 1'b1;
    endtask : irq_poll_prog
    // Main sequence
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        proc_mode_prog();
        comp_mode_prog();
        irq_poll_prog();
        final_report(1'b0);
    end
endmodule : dspd_core_tb
`default_nettype wire

/* tb/dspd_ext_mem.sv */
// External program memory and port devices on the core's data bus
`timescale 1ns/1ps
`default_nettype none
module dspd_ext_mem
    import dspd_pkg::*;
(
    input wire logic hclk, // Clock
    input wire dspd_bus_s ext_bus, // Core pins
    output logic [15:0] ext_din // Data bus to core
);
    logic [15:0] prog [4096];
    logic [15:0] port_in [8];
    logic [15:0] last = 16'h0000;
    logic [2:0] out_port;
    logic [15:0] out_word;
    // Released bus toggles each cycle so a stray sample never looks valid
    always_comb begin
        if (!ext_bus.men_n) ext_din = prog[ext_bus.addr];
        else if (!ext_bus.den_n) ext_din = port_in[ext_bus.addr[2:0]];
        else ext_din = ~last;
    end
    // Port write capture
    always_ff @(posedge hclk) begin
        last <= ext_din;
        if (!ext_bus.we_n) begin
            out_port <= ext_bus.addr[2:0];
            out_word <= ext_bus.dout;
        end
    end
endmodule : dspd_ext_mem
`default_nettype wire
